// ==== logic/ffo_params.svh ====
`ifndef FFO_PARAMS_SVH
`define FFO_PARAMS_SVH

// Storage geometry
`define FFO_DW         8
`define FFO_AW         4
`define FFO_DEPTH      16
`define FFO_FULL_CNT   5'h10
`define FFO_CW         5

// Synchroniser chains
`define FFO_SYNC_MAX   5
`define FFO_SEL_MIN    2'h0

// Register byte addresses
`define FFO_A_CTRL     8'h00
`define FFO_A_THR      8'h04
`define FFO_A_STAT     8'h08
`define FFO_A_IST      8'h0c
`define FFO_A_ICLR     8'h10
`define FFO_A_IEN      8'h14

// Control register fields
`define FFO_C_DUAL     0
`define FFO_C_CLRSYNC  1
`define FFO_C_REL      2
`define FFO_C_OREG     3
`define FFO_C_RDD      4
`define FFO_C_WRD      6

// Threshold register fields
`define FFO_T_NF       0
`define FFO_T_NE       16

// Interrupt bits
`define FFO_I_OVF      0
`define FFO_I_UDF      1
`define FFO_I_NF       2
`define FFO_I_CLR      3
`define FFO_IW         4

// Reset values
`define FFO_CTRL_RST   8'h00
`define FFO_NF_RST     5'h0c
`define FFO_NE_RST     5'h04

`endif

// ==== logic/ffo_pkg.sv ====
`include "ffo_params.svh"

package ffo_pkg;
	typedef logic [`FFO_DW-1:0] ffo_data_t;
	typedef logic [`FFO_AW:0]   ffo_ptr_t;
	typedef logic [`FFO_CW-1:0] ffo_cnt_t;
endpackage : ffo_pkg

// ==== logic/ffo_sync.sv ====
`timescale 1ns/100ps
`include "ffo_params.svh"

module ffo_sync
	import ffo_pkg::*;
#(
	parameter int W = 1
)(
	// Clock and control
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic         clr_i,
	input  wire logic [1:0]   sel_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [`FFO_SYNC_MAX-1:0][W-1:0] stg;
	} ffo_sync_s;

	ffo_sync_s st;
	ffo_sync_s next_st;

	always_comb begin
		next_st = st;
		if (!rst_n_i || clr_i) begin
			next_st = '0;
		end else begin
			next_st.stg[0] = d_i;
			for (int i = 1; i < `FFO_SYNC_MAX; i++) begin
				next_st.stg[i] = st.stg[i-1];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || ce_i) begin
			st <= next_st;
		end
	end

	// Tap never reads the first stage, so at least two flops always sit in the path
	assign q_o = st.stg[{1'b0, sel_i} + 3'h1];

endmodule : ffo_sync

// ==== logic/ffo_top.sv ====
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "ffo_params.svh"

// Operation
// - Optional clear resynchronised on read side, default off
// - Read requests held off while clear settles
// - Related-clocks setting bypasses the crossing chains, default false
// - Optional read data register, default off
// - Near-full when count at least threshold
// - Near-empty when count below threshold
// - Output register, near flags: single-clock only
// - Related and depth settings: dual-clock only
// - Depth settings size each crossing chain
module ffo_top
	import ffo_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                SYS_CLK_I,
	input  wire logic                RESET_N_I,
	input  wire logic                CE_I,
	// Asynchronous clear pin
	input  wire logic                ACLR_I,
	// Write side
	input  wire logic                WR_REQ_I,
	input  wire logic [`FFO_DW-1:0]  WR_DATA_I,
	output logic                     FULL_O,
	output logic                     NEAR_FULL_O,
	output logic      [`FFO_CW-1:0]  USED_O,
	// Read side
	input  wire logic                RD_REQ_I,
	output logic      [`FFO_DW-1:0]  RD_DATA_O,
	output logic                     EMPTY_O,
	output logic                     NEAR_EMPTY_O,
	// APB slave
	input  wire logic                PSEL_I,
	input  wire logic                PENABLE_I,
	input  wire logic                PWRITE_I,
	input  wire logic [7:0]          PADDR_I,
	input  wire logic [31:0]         PWDATA_I,
	output logic      [31:0]         PRDATA_O,
	output logic                     PREADY_O,
	output logic                     PSLVERR_O,
	// Interrupt
	output logic                     IRQ_O
);

	typedef struct packed {
		logic [`FFO_DEPTH-1:0][`FFO_DW-1:0] mem;
		ffo_ptr_t                           wr_ptr;
		ffo_ptr_t                           rd_ptr;
		ffo_data_t                          rdata;
		ffo_data_t                          q;
		logic [7:0]                         ctrl;
		ffo_cnt_t                           nf;
		ffo_cnt_t                           ne;
		logic [`FFO_IW-1:0]                 irq_st;
		logic [`FFO_IW-1:0]                 irq_en;
		ffo_cnt_t                           count;
		logic                               empty;
		logic                               full;
		logic                               nfull;
		logic                               nempty;
		logic                               clr_d;
		logic                               rd_pend;
		logic                               irq;
		logic [31:0]                        prdata;
		logic                               pready;
		logic                               pslverr;
	} ffo_st_s;

	ffo_st_s            st;
	ffo_st_s            next_st;

	logic               aclr_s;
	logic               aclr_r;
	logic               wr_clr;
	logic               rd_clr;
	logic               clr_any;
	logic               dual;
	logic               xing;
	logic               oreg_on;
	logic               wr_fire;
	logic               rd_fire;
	logic               setup;
	logic               access;
	ffo_ptr_t           wsync_q;
	ffo_ptr_t           rsync_q;
	ffo_ptr_t           wv;
	ffo_ptr_t           rv;
	ffo_cnt_t           cnt_w;
	ffo_cnt_t           cnt_r;
	logic [31:0]        rd_word;
	logic               rd_err;
	logic [`FFO_IW-1:0] ev;
	logic [`FFO_IW-1:0] clr_mask;

	// Option decode
	assign dual    = st.ctrl[`FFO_C_DUAL];
	assign xing    = dual & ~st.ctrl[`FFO_C_REL];
	assign oreg_on = st.ctrl[`FFO_C_OREG] & ~dual;

	// Clear pin is asynchronous: two flops before anything looks at it
	ffo_sync #(.W(1)) u_pin_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESET_N_I),
		.ce_i    (CE_I),
		.clr_i   (1'b0),
		.sel_i   (`FFO_SEL_MIN),
		.d_i     (ACLR_I),
		.q_o     (aclr_s)
	);

	// Extra read-side resynchronisation of the clear
	ffo_sync #(.W(1)) u_rclr_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESET_N_I),
		.ce_i    (CE_I),
		.clr_i   (1'b0),
		.sel_i   (`FFO_SEL_MIN),
		.d_i     (aclr_s),
		.q_o     (aclr_r)
	);

	assign wr_clr  = aclr_s;
	assign rd_clr  = st.ctrl[`FFO_C_CLRSYNC] ? aclr_r : aclr_s;
	assign clr_any = wr_clr | rd_clr;

	// Both ports wait until every side has seen the clear, so no request
	// can race it and leave the pointers disagreeing
	assign wr_fire = WR_REQ_I & ~st.full & ~clr_any;
	assign rd_fire = RD_REQ_I & ~st.empty & ~clr_any;

	// Pointer crossings; binary is safe because both sides share one clock
	ffo_sync #(.W(`FFO_AW+1)) u_w2r_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESET_N_I),
		.ce_i    (CE_I),
		.clr_i   (rd_clr),
		.sel_i   (st.ctrl[`FFO_C_RDD +: 2]),
		.d_i     (st.wr_ptr),
		.q_o     (wsync_q)
	);

	ffo_sync #(.W(`FFO_AW+1)) u_r2w_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESET_N_I),
		.ce_i    (CE_I),
		.clr_i   (wr_clr),
		.sel_i   (st.ctrl[`FFO_C_WRD +: 2]),
		.d_i     (st.rd_ptr),
		.q_o     (rsync_q)
	);

	// APB phases
	assign setup  = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I & st.pready;

	always_comb begin
		rd_word = '0;
		rd_err  = 1'b0;
		case (PADDR_I)
			`FFO_A_CTRL: rd_word[7:0] = st.ctrl;
			`FFO_A_THR: begin
				rd_word[`FFO_T_NF +: `FFO_CW] = st.nf;
				rd_word[`FFO_T_NE +: `FFO_CW] = st.ne;
			end
			`FFO_A_STAT: rd_word = {20'h0, st.nempty, st.nfull, st.full, st.empty,
				3'h0, st.count};
			`FFO_A_IST:  rd_word[`FFO_IW-1:0] = st.irq_st;
			`FFO_A_ICLR: rd_word = '0;
			`FFO_A_IEN:  rd_word[`FFO_IW-1:0] = st.irq_en;
			default:     rd_err = 1'b1;
		endcase
	end

	always_comb begin
		next_st  = st;
		ev       = '0;
		clr_mask = '0;
		wv       = '0;
		rv       = '0;
		cnt_w    = '0;
		cnt_r    = '0;
		if (!RESET_N_I) begin
			next_st        = '0;
			next_st.ctrl   = `FFO_CTRL_RST;
			next_st.nf     = `FFO_NF_RST;
			next_st.ne     = `FFO_NE_RST;
			next_st.empty  = 1'b1;
			next_st.nempty = 1'b1;
		end else begin
			// Register writes land at the access edge only
			if (access && PWRITE_I) begin
				case (PADDR_I)
					`FFO_A_CTRL: next_st.ctrl = PWDATA_I[7:0];
					`FFO_A_THR: begin
						next_st.nf = PWDATA_I[`FFO_T_NF +: `FFO_CW];
						next_st.ne = PWDATA_I[`FFO_T_NE +: `FFO_CW];
					end
					`FFO_A_ICLR: clr_mask = PWDATA_I[`FFO_IW-1:0];
					`FFO_A_IEN:  next_st.irq_en = PWDATA_I[`FFO_IW-1:0];
					default: ;
				endcase
			end
			next_st.pready = setup;
			if (setup) begin
				next_st.prdata  = rd_word;
				next_st.pslverr = rd_err;
			end

			// Write side
			if (wr_clr) begin
				next_st.wr_ptr = '0;
			end else if (wr_fire) begin
				next_st.mem[st.wr_ptr[`FFO_AW-1:0]] = WR_DATA_I;
				next_st.wr_ptr = st.wr_ptr + 1'b1;
			end

			// Read side; the registered option copies only after a read, so
			// the output stands between reads as in the direct option
			if (st.rd_pend) begin
				next_st.q = st.rdata;
			end
			next_st.rd_pend = 1'b0;
			if (rd_clr) begin
				next_st.rd_ptr = '0;
			end else if (rd_fire) begin
				next_st.rd_ptr = st.rd_ptr + 1'b1;
				if (oreg_on) begin
					next_st.rdata = st.mem[st.rd_ptr[`FFO_AW-1:0]];
					next_st.rd_pend = 1'b1;
				end else begin
					next_st.q = st.mem[st.rd_ptr[`FFO_AW-1:0]];
				end
			end

			// With unrelated dual clocks each side judges the other through its crossing chain, so
			// flags can lag but never claim room or data that is not there
			wv    = (xing && !rd_clr) ? wsync_q : next_st.wr_ptr;
			rv    = (xing && !wr_clr) ? rsync_q : next_st.rd_ptr;
			cnt_w = next_st.wr_ptr - rv;
			cnt_r = wv - next_st.rd_ptr;
			next_st.count  = cnt_w;
			next_st.full   = (cnt_w == `FFO_FULL_CNT);
			next_st.empty  = (cnt_r == '0);
			next_st.nfull  = ~next_st.ctrl[`FFO_C_DUAL] &
				(cnt_w >= next_st.nf);
			next_st.nempty = ~next_st.ctrl[`FFO_C_DUAL] &
				(cnt_w < next_st.ne);

			// Events; a new event beats a simultaneous clear
			ev[`FFO_I_OVF] = WR_REQ_I & st.full & ~clr_any;
			ev[`FFO_I_UDF] = RD_REQ_I & st.empty & ~clr_any;
			ev[`FFO_I_NF]  = next_st.nfull & ~st.nfull;
			ev[`FFO_I_CLR] = wr_clr & ~st.clr_d;
			next_st.clr_d  = wr_clr;
			next_st.irq_st = (st.irq_st & ~clr_mask) | ev;
			next_st.irq    = |(next_st.irq_st & next_st.irq_en);
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I || CE_I) begin
			st <= next_st;
		end
	end

	assign FULL_O       = st.full;
	assign NEAR_FULL_O  = st.nfull;
	assign USED_O       = st.count;
	assign RD_DATA_O    = st.q;
	assign EMPTY_O      = st.empty;
	assign NEAR_EMPTY_O = st.nempty;
	assign PRDATA_O     = st.prdata;
	assign PREADY_O     = st.pready;
	assign PSLVERR_O    = st.pslverr;
	assign IRQ_O        = st.irq;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	sequence s_rd_reg;
		rd_fire && oreg_on && CE_I ##1 CE_I && oreg_on;
	endsequence

	sequence s_full_clear;
		wr_clr && rd_clr && CE_I;
	endsequence

	a_near_full_flag: assert property (
		!dual |-> NEAR_FULL_O == (USED_O >= st.nf))
		else $error("near-full flag disagrees with count");

	a_near_empty_flag: assert property (
		!dual |-> NEAR_EMPTY_O == (USED_O < st.ne))
		else $error("near-empty flag disagrees with count");

	a_dual_flags_off: assert property (
		dual |-> !NEAR_FULL_O && !NEAR_EMPTY_O)
		else $error("near flags active in dual-clock variant");

	a_out_direct: assert property (
		rd_fire && !oreg_on && CE_I |=> RD_DATA_O == $past(st.mem[st.rd_ptr[`FFO_AW-1:0]]))
		else $error("unregistered read data not shown after one cycle");

	a_out_registered: assert property (
		s_rd_reg |=> RD_DATA_O == $past(st.mem[st.rd_ptr[`FFO_AW-1:0]], 2))
		else $error("registered read data not shown after two cycles");

	a_clear_empties: assert property (
		s_full_clear |=> USED_O == '0 && EMPTY_O && !FULL_O && !NEAR_FULL_O)
		else $error("clear did not empty the FIFO");

	a_rd_clear_sync: assert property (
		(st.ctrl[`FFO_C_CLRSYNC] && aclr_s && CE_I) [*3] |-> rd_clr ##1 !rd_fire)
		else $error("read-side clear did not follow within two cycles");

	a_sync_depth: assert property (
		(xing && st.ctrl[`FFO_C_RDD +: 2] == 2'h0 && CE_I && !rd_clr) [*3]
		|-> wsync_q == $past(st.wr_ptr, 2))
		else $error("write pointer crossing not two stages deep");

	a_apb_ready: assert property (
		setup && CE_I |=> PREADY_O ##1 (!PREADY_O || !CE_I || $past(setup)))
		else $error("APB ready not given in the access phase");

	a_wr_count_up: assert property (
		wr_fire && !rd_fire && !dual && CE_I |=> USED_O == $past(USED_O) + 5'h1)
		else $error("stored-word count did not rise on a write");

	a_rd_count_down: assert property (
		rd_fire && !wr_fire && !dual && CE_I |=> USED_O == $past(USED_O) - 5'h1)
		else $error("stored-word count did not fall on a read");

	a_out_stands: assert property (
		!rd_fire && !st.rd_pend |=> $stable(RD_DATA_O))
		else $error("read data changed without a read");

endmodule : ffo_top

// ==== bench/ffo_user.sv ====
`timescale 1ns/100ps

module ffo_user
	import ffo_pkg::*;
(
	// Clock
	input  wire logic clk_i,
	// Requests towards the FIFO
	output ffo_data_t wr_data_o,
	output logic      wr_req_o,
	output logic      rd_req_o
);
	initial begin
		wr_req_o = 1'b0;
		rd_req_o = 1'b0;
		wr_data_o = 8'h00;
	end

	task push(input ffo_data_t d);
		@(posedge clk_i);
		wr_req_o  <= 1'b1;
		wr_data_o <= d;
		@(posedge clk_i);
		wr_req_o  <= 1'b0;
		// Idle bus shows a changed value so a stale word cannot pass
		wr_data_o <= ~d;
	endtask : push

	task pop;
		@(posedge clk_i);
		rd_req_o <= 1'b1;
		@(posedge clk_i);
		rd_req_o <= 1'b0;
	endtask : pop
endmodule : ffo_user

// ==== bench/fifo_flag_and_sync_options_bench.sv ====
`timescale 1ns/100ps
`include "ffo_params.svh"

module fifo_flag_and_sync_options_bench;
	logic        sys_clk, reset_n, aclr, psel, penable, pwrite, err, ce;
	logic        full, nfull, empty, nempty, pready, pslverr, irq, wr_req, rd_req;
	logic [7:0]  paddr, wr_data, rd_data;
	logic [31:0] pwdata, prdata, rdat;
	logic [4:0]  used;
	int          error_cnt, samples_checked;
	// Shared clock, so related is legitimate unrelated gets a depth
	logic [31:0] cv [4] = '{32'h30, 32'h05, 32'h01, 32'h31};
	logic        ee [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

	ffo_top dut_u (.SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .CE_I(ce), .ACLR_I(aclr),
		.WR_REQ_I(wr_req), .WR_DATA_I(wr_data), .FULL_O(full), .NEAR_FULL_O(nfull),
		.USED_O(used), .RD_REQ_I(rd_req), .RD_DATA_O(rd_data), .EMPTY_O(empty),
		.NEAR_EMPTY_O(nempty), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .IRQ_O(irq));

	ffo_user usr_u (.clk_i(sys_clk), .wr_data_o(wr_data), .wr_req_o(wr_req),
		.rd_req_o(rd_req));

	always #50 sys_clk = ~sys_clk;

	task end_sim;
		$display("errors %0d, checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Ready is read once settled; ready drops at the next edge, the answer stands through it
		#1;
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		rdat = prdata;
		err  = pslverr;
		@(posedge sys_clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp, m);
	endtask : rd

	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		end_sim();
	end

	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		aclr = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		#1;
		chk(empty, 1'b1, "empty after reset");
		rd(`FFO_A_CTRL, 32'h0, "ctrl reset");
		rd(`FFO_A_THR, 32'h0004000c, "thr reset");
		rd(`FFO_A_STAT, 32'h00000900, "status reset");
		apb(1'b1, 8'h40, 32'h0);
		chk(err, 1'b1, "unmapped slverr");
		apb(1'b1, `FFO_A_THR, 32'h00020003);
		for (int i = 1; i <= 16; i++) begin
			usr_u.push(8'h30 + i[7:0]);
			#1;
			chk({27'h0, used}, i, "used count");
			chk(nfull, i >= 3, "near full");
			chk(nempty, i < 2, "near empty");
		end
		chk(full, 1'b1, "full");
		usr_u.push(8'hff);
		rd(`FFO_A_IST, 32'h5, "overflow status");
		for (int i = 1; i <= 16; i++) begin
			usr_u.pop();
			#1;
			chk(rd_data, 8'h30 + i[7:0], "read order");
		end
		usr_u.pop();
		rd(`FFO_A_IST, 32'h7, "underflow status");
		apb(1'b1, `FFO_A_IEN, 32'h2);
		@(posedge sys_clk);
		#1;
		chk(irq, 1'b1, "irq raised");
		apb(1'b1, `FFO_A_ICLR, 32'h7);
		@(posedge sys_clk);
		#1;
		chk(irq, 1'b0, "irq cleared");
		rd(`FFO_A_IST, 32'h0, "status cleared");
		apb(1'b1, `FFO_A_CTRL, 32'h08);
		usr_u.push(8'ha5);
		usr_u.pop();
		#1;
		chk(rd_data, 8'h40, "reg output late");
		@(posedge sys_clk);
		#1;
		chk(rd_data, 8'ha5, "reg output data");
		apb(1'b1, `FFO_A_CTRL, 32'h02);
		for (int i = 0; i < 3; i++) usr_u.push(8'h50);
		@(posedge sys_clk);
		aclr <= 1'b1;
		usr_u.pop();
		@(posedge sys_clk);
		aclr <= 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		chk({used, empty, full, nfull}, {5'h0, 3'b100}, "clear state");
		apb(1'b0, `FFO_A_IST, 32'h0);
		chk(rdat & 32'h8, 32'h8, "clear status");
		usr_u.push(8'h5a);
		usr_u.pop();
		#1;
		chk(rd_data, 8'h5a, "usable after clear");
		@(posedge sys_clk);
		ce <= 1'b0;
		usr_u.push(8'h77);
		#1;
		chk({used, empty}, {5'h0, 1'b1}, "enable low freezes");
		@(posedge sys_clk);
		ce <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `FFO_A_CTRL, cv[k]);
			usr_u.push(8'h60 + k[7:0]);
			@(posedge sys_clk);
			#1;
			chk(empty, ee[k], "read side delay");
			chk({nfull, nempty}, {1'b0, ~cv[k][`FFO_C_DUAL]}, "near flags");
			repeat (8) @(posedge sys_clk);
			usr_u.pop();
			#1;
			chk(rd_data, 8'h60 + k[7:0], "variant data");
		end
		end_sim();
	end
endmodule : fifo_flag_and_sync_options_bench
